// File: tcs_regs.vh
/*
  register map, field positions, reset values and timing figures of the
  touch conversion sequencer. assumes word-indexed registers on a 32-bit
  bus, byte address = 4 * index.
*/
`ifndef TCS_REGS_VH
`define TCS_REGS_VH

`define TCS_IDX_CTRL1        4'h1
`define TCS_IDX_CTRL2        4'h2
`define TCS_IDX_CTRL3        4'h3
`define TCS_IDX_LIM_AUX_HI   4'h4
`define TCS_IDX_LIM_AUX_LO   4'h5
`define TCS_IDX_LIM_TEMP_HI  4'h6
`define TCS_IDX_LIM_TEMP_LO  4'h7
`define TCS_IDX_RES_FIRST    4'h8
`define TCS_IDX_RES_LAST     4'hd
`define TCS_IDX_ID           4'he

`define TCS_C1_PEN           15
`define TCS_C1_CHAN_HI       14
`define TCS_C1_CHAN_LO       12
`define TCS_C1_MODE_HI       11
`define TCS_C1_MODE_LO       10
`define TCS_C1_ACQ_HI        9
`define TCS_C1_ACQ_LO        8
`define TCS_C1_TMR_HI        7
`define TCS_C1_TMR_LO        0

`define TCS_C2_GPIO_EN       13
`define TCS_C2_SWRST         4
`define TCS_C2_SETTLE_HI     3
`define TCS_C2_SETTLE_LO     0

`define TCS_C3_TEMP_MASK     15
`define TCS_C3_AUX_MASK      14
`define TCS_C3_INT_MODE      13
`define TCS_C3_GPIO_MASK     12
`define TCS_C3_FLAG_HI       11
`define TCS_C3_FLAG_LO       8
`define TCS_C3_SEL_HI        7
`define TCS_C3_SEL_LO        1

`define TCS_MODE_IDLE        2'b00
`define TCS_MODE_SINGLE      2'b01
`define TCS_MODE_SLAVE       2'b10
`define TCS_MODE_AUTO        2'b11

`define TCS_RST_16           16'h0000

`define TCS_SYS_CLK_KHZ      10000
`define TCS_CONV_CLK_KHZ     2000
`define TCS_TMR_BASE_US      550
`define TCS_TMR_STEP_US      35
`define TCS_SETTLE_UNIT_US   128
`define TCS_ACQ_MIN_PERIODS  4

`endif

// File: tcs_sequencer.v
/*
  touch conversion sequencer: register file, channel sequencer, interval
  timer, settling and sampling windows, limit checks and alert outputs.
  assumes a classic wishbone master, an external converter core that
  answers conv_start_o with conv_done_i and 12-bit data, and synchronous
  touch_i and gpio_alert_i levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.vh"

module tcs_sequencer #(
  parameter ID_REV           = 4'h1,
  parameter ID_DEV           = 8'h5a,
  parameter CONV_DIV         = `TCS_SYS_CLK_KHZ / `TCS_CONV_CLK_KHZ,
  parameter TMR_BASE_TICKS   = `TCS_TMR_BASE_US * `TCS_CONV_CLK_KHZ / 1000,
  parameter TMR_STEP_TICKS   = `TCS_TMR_STEP_US * `TCS_CONV_CLK_KHZ / 1000,
  parameter SETTLE_UNIT_TICKS = `TCS_SETTLE_UNIT_US * `TCS_CONV_CLK_KHZ / 1000,
  parameter CNT_W            = 24
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        touch_i,
  input  wire        gpio_alert_i,
  input  wire        conv_done_i,
  input  wire [11:0] conv_data_i,
  output reg         conv_start_o,
  output reg  [2:0]  conv_channel_o,
  output reg         sample_o,
  output reg         irq_n_o,
  output reg         touch_detect_output_n_o
);

  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_WAIT   = 3'd1;
  localparam [2:0] ST_PICK   = 3'd2;
  localparam [2:0] ST_SETTLE = 3'd3;
  localparam [2:0] ST_ACQ    = 3'd4;
  localparam [2:0] ST_CONV   = 3'd5;
  localparam [2:0] ST_GAP    = 3'd6;

  reg  [15:0]      ctrl1_r;
  reg  [15:0]      ctrl2_r;
  reg  [3:0]       cfg3_r;
  reg  [6:0]       sel3_r;
  reg  [3:0]       flag_r;
  reg  [15:0]      lim_r [0:3];
  reg  [15:0]      res_r [0:5];
  reg              dav_r;
  reg              srst_r;
  reg  [2:0]       st_r;
  reg  [6:0]       pend_r;
  reg              first_r;
  reg  [2:0]       cur_r;
  reg              armed_r;
  reg  [CNT_W-1:0] cnt_r;
  reg  [7:0]       div_r;
  reg              tick_r;
  reg  [15:0]      rd_val;
  integer          i;

  wire        core_rst_n = rst_n & ~srst_r;
  wire        req        = wb_cyc_i & wb_stb_i;
  wire        acc        = req & wb_ack_o;
  wire        mapped     = (wb_adr_i[7:6] == 2'b00);
  wire [3:0]  idx        = wb_adr_i[5:2];
  wire        wr         = acc & wb_we_i & mapped;
  wire        rd         = acc & ~wb_we_i & mapped;
  wire        wr_c1      = wr & (idx == `TCS_IDX_CTRL1);
  wire        wr_c2      = wr & (idx == `TCS_IDX_CTRL2);
  wire        wr_c3      = wr & (idx == `TCS_IDX_CTRL3);
  wire        rd_res     = rd & (idx >= `TCS_IDX_RES_FIRST) & (idx <= `TCS_IDX_RES_LAST);

  wire [1:0]  mode       = ctrl1_r[`TCS_C1_MODE_HI:`TCS_C1_MODE_LO];
  wire [7:0]  tmr        = ctrl1_r[`TCS_C1_TMR_HI:`TCS_C1_TMR_LO];
  wire [1:0]  sampling_window_code        = ctrl1_r[`TCS_C1_ACQ_HI:`TCS_C1_ACQ_LO];
  wire [2:0]  chan       = ctrl1_r[`TCS_C1_CHAN_HI:`TCS_C1_CHAN_LO];
  wire [3:0]  settle     = ctrl2_r[`TCS_C2_SETTLE_HI:`TCS_C2_SETTLE_LO];
  wire        gpio_en    = ctrl2_r[`TCS_C2_GPIO_EN];
  wire        int_mode   = cfg3_r[`TCS_C3_INT_MODE - 12];

  function [15:0] merge;
    input [15:0] old;
    input [15:0] d;
    input [1:0]  sel;
    begin
      merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // highest pending bit wins, so position channels go first
  function [2:0] top_idx;
    input [6:0] p;
    integer k;
    begin
      top_idx = 3'd0;
      for (k = 0; k < 7; k = k + 1) begin
        if (p[k])
          top_idx = k[2:0];
      end
    end
  endfunction

  function [5:0] settle_mult;
    input [3:0] code;
    begin
      case (code)
        4'ha:    settle_mult = 6'd12;
        4'hb:    settle_mult = 6'd14;
        4'hc:    settle_mult = 6'd16;
        4'hd:    settle_mult = 6'd20;
        4'he:    settle_mult = 6'd28;
        4'hf:    settle_mult = 6'd32;
        default: settle_mult = {2'b00, code} + 6'd1;
      endcase
    end
  endfunction

  wire [15:0] c1_wval   = merge(ctrl1_r, wb_dat_i[15:0], wb_sel_i[1:0]);
  wire [15:0] c2_wval   = merge(ctrl2_r, wb_dat_i[15:0], wb_sel_i[1:0]);
  wire [15:0] c3_old    = {cfg3_r, flag_r, sel3_r, 1'b0};
  wire [15:0] c3_wval   = merge(c3_old, wb_dat_i[15:0], wb_sel_i[1:0]);
  wire [1:0]  new_mode  = c1_wval[`TCS_C1_MODE_HI:`TCS_C1_MODE_LO];

  // channel set for a sequence: pin use drops aux and battery
  wire [6:0]  seq_mask  = gpio_en ? (sel3_r & 7'b1111001) :
                          (sel3_r[2] & sel3_r[1]) ? (sel3_r & 7'b1111011) : sel3_r;
  wire [6:0]  sgl_mask  = (chan == 3'd0) ? 7'h00 : (7'h01 << (chan - 3'd1));
  wire [6:0]  start_msk = (mode == `TCS_MODE_SINGLE) ? sgl_mask : seq_mask;

  wire [2:0]  nxt_idx   = top_idx(pend_r);
  wire        finish    = (st_r == ST_PICK) && (pend_r == 7'h00);
  wire        clr_mode  = finish && (tmr == 8'h00) && (mode != `TCS_MODE_AUTO);
  wire        conv_ok   = (st_r == ST_CONV) && conv_done_i;
  wire [15:0] res_val   = {4'h0, conv_data_i};
  wire [2:0]  res_slot  = (cur_r >= 3'd3) ? (3'd6 - cur_r) :
                          (cur_r == 3'd0) ? 3'd5 : 3'd4;

  wire [31:0] acq_ticks = `TCS_ACQ_MIN_PERIODS << sampling_window_code;
  wire [31:0] set_ticks = settle_mult(settle) * SETTLE_UNIT_TICKS;
  wire [31:0] gap_ticks = TMR_BASE_TICKS + TMR_STEP_TICKS * ({24'h0, tmr} - 32'd1);
  wire        cnt_done  = (cnt_r == {CNT_W{1'b0}});

  // masked limit alert, only meaningful in limit-alert mode
  wire        alert     = int_mode & (
                          (|flag_r[3:2] & ~cfg3_r[`TCS_C3_AUX_MASK - 12]) |
                          (|flag_r[1:0] & ~cfg3_r[`TCS_C3_TEMP_MASK - 12]) |
                          (gpio_alert_i & ~cfg3_r[`TCS_C3_GPIO_MASK - 12]));

  // bus slave: ack one cycle after the request, dropped the cycle after
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      srst_r   <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o)
        wb_dat_o <= {16'h0000, rd_val};
      srst_r <= wr_c2 & c2_wval[`TCS_C2_SWRST];
    end
  end

  always @* begin
    rd_val = 16'h0000;
    if (mapped) begin
      case (idx)
        `TCS_IDX_CTRL1:       rd_val = ctrl1_r;
        `TCS_IDX_CTRL2:       rd_val = ctrl2_r;
        `TCS_IDX_CTRL3:       rd_val = c3_old;
        `TCS_IDX_LIM_AUX_HI:  rd_val = lim_r[0];
        `TCS_IDX_LIM_AUX_LO:  rd_val = lim_r[1];
        `TCS_IDX_LIM_TEMP_HI: rd_val = lim_r[2];
        `TCS_IDX_LIM_TEMP_LO: rd_val = lim_r[3];
        4'h8:                 rd_val = res_r[0];
        4'h9:                 rd_val = res_r[1];
        4'ha:                 rd_val = res_r[2];
        4'hb:                 rd_val = res_r[3];
        4'hc:                 rd_val = res_r[4];
        4'hd:                 rd_val = res_r[5];
        `TCS_IDX_ID:          rd_val = {4'h0, ID_REV[3:0], ID_DEV[7:0]};
        default:              rd_val = 16'h0000;
      endcase
    end
  end

  // register file; hardware sets win over a software write
  always @(posedge sys_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ctrl1_r <= `TCS_RST_16;
      ctrl2_r <= `TCS_RST_16;
      cfg3_r  <= 4'h0;
      sel3_r  <= 7'h00;
      flag_r  <= 4'h0;
      dav_r   <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        lim_r[i] <= `TCS_RST_16;
      for (i = 0; i < 6; i = i + 1)
        res_r[i] <= `TCS_RST_16;
    end else begin
      if (wr_c1)
        ctrl1_r <= c1_wval;
      else if (clr_mode)
        ctrl1_r[`TCS_C1_MODE_HI:`TCS_C1_MODE_LO] <= `TCS_MODE_IDLE;
      if (wr_c2)
        ctrl2_r <= {c2_wval[15:5], 1'b0, c2_wval[3:0]};
      if (wr_c3) begin
        cfg3_r <= c3_wval[15:12];
        sel3_r <= c3_wval[`TCS_C3_SEL_HI:`TCS_C3_SEL_LO];
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (wr && (idx == `TCS_IDX_LIM_AUX_HI + i[3:0]))
          lim_r[i] <= merge(lim_r[i], wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (conv_ok)
        res_r[res_slot] <= res_val;
      // flags: written value holds unless a limit breach sets the bit
      flag_r <= (wr_c3 ? c3_wval[`TCS_C3_FLAG_HI:`TCS_C3_FLAG_LO] : flag_r) | {
                conv_ok && (res_slot == 3'd4) && (res_val < lim_r[1]),
                conv_ok && (res_slot == 3'd4) && (res_val > lim_r[0]),
                conv_ok && (res_slot == 3'd5) && (res_val < lim_r[3]),
                conv_ok && (res_slot == 3'd5) && (res_val > lim_r[2])};
      dav_r <= conv_ok | (dav_r & ~rd_res);
    end
  end

  // converter clock tick derived from the system clock
  always @(posedge sys_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      if (div_r == CONV_DIV[7:0] - 8'd1) begin
        div_r  <= 8'h00;
        tick_r <= 1'b1;
      end else begin
        div_r  <= div_r + 8'd1;
        tick_r <= 1'b0;
      end
    end
  end

  // armed: a fresh touch may start an autonomous sequence
  always @(posedge sys_clk or negedge core_rst_n) begin
    if (!core_rst_n)
      armed_r <= 1'b0;
    else if (!touch_i || (wr_c1 && new_mode == `TCS_MODE_AUTO))
      armed_r <= 1'b1;
    else if (finish && mode == `TCS_MODE_AUTO && tmr == 8'h00)
      armed_r <= 1'b0;
  end

  // channel sequencer
  always @(posedge sys_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      st_r           <= ST_IDLE;
      pend_r         <= 7'h00;
      first_r        <= 1'b0;
      cur_r          <= 3'd0;
      cnt_r          <= {CNT_W{1'b0}};
      conv_start_o   <= 1'b0;
      conv_channel_o <= 3'd0;
      sample_o       <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      if (tick_r && !cnt_done)
        cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      if (wr_c1) begin
        sample_o <= 1'b0;
        case (new_mode)
          `TCS_MODE_IDLE: st_r <= ST_IDLE;
          `TCS_MODE_AUTO: st_r <= ST_WAIT;
          default:        st_r <= ST_WAIT;
        endcase
      end else begin
        case (st_r)
          ST_IDLE: st_r <= ST_IDLE;
          ST_WAIT: begin
            if (mode != `TCS_MODE_AUTO || (touch_i && armed_r)) begin
              pend_r  <= start_msk;
              first_r <= 1'b1;
              st_r    <= ST_PICK;
            end
          end
          ST_PICK: begin
            if (pend_r == 7'h00) begin
              if (tmr == 8'h00)
                st_r <= (mode == `TCS_MODE_AUTO) ? ST_WAIT : ST_IDLE;
              else if (mode == `TCS_MODE_AUTO && !touch_i)
                st_r <= ST_WAIT;
              else begin
                cnt_r <= gap_ticks[CNT_W-1:0];
                st_r  <= ST_GAP;
              end
            end else begin
              cur_r          <= nxt_idx;
              conv_channel_o <= nxt_idx + 3'd1;
              if (first_r || nxt_idx >= 3'd3) begin
                cnt_r <= set_ticks[CNT_W-1:0];
                st_r  <= ST_SETTLE;
              end else begin
                cnt_r    <= acq_ticks[CNT_W-1:0];
                sample_o <= 1'b1;
                st_r     <= ST_ACQ;
              end
            end
          end
          ST_SETTLE: begin
            if (cnt_done) begin
              cnt_r    <= acq_ticks[CNT_W-1:0];
              sample_o <= 1'b1;
              st_r     <= ST_ACQ;
            end
          end
          ST_ACQ: begin
            if (cnt_done) begin
              sample_o     <= 1'b0;
              conv_start_o <= 1'b1;
              st_r         <= ST_CONV;
            end
          end
          ST_CONV: begin
            if (conv_done_i) begin
              pend_r[cur_r] <= 1'b0;
              first_r       <= 1'b0;
              st_r          <= ST_PICK;
            end
          end
          ST_GAP: begin
            if (mode == `TCS_MODE_AUTO && !touch_i)
              st_r <= ST_WAIT;
            else if (cnt_done) begin
              pend_r  <= start_msk;
              first_r <= 1'b1;
              st_r    <= ST_PICK;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // touch pin: touch when pen bit clear, limit alert when set; irq pin: limit alert in limit-alert mode, else data ready
  always @(posedge sys_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      irq_n_o                 <= 1'b1;
      touch_detect_output_n_o <= 1'b1;
    end else begin
      irq_n_o                 <= int_mode ? ~alert : ~dav_r;
      touch_detect_output_n_o <= ctrl1_r[`TCS_C1_PEN] ? ~alert : ~touch_i;
    end
  end

endmodule

`default_nettype wire

// File: tcs_seq_monitor.sv
/*
  port checker for the touch conversion sequencer.
  assumes classic wishbone requests and one converter handshake at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module tcs_seq_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        conv_start_o,
  input wire logic [2:0]  conv_channel_o,
  input wire logic        sample_o,
  input wire logic        irq_n_o
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_dat_hi;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read half set");
  property p_start_pulse;
    conv_start_o |=> !conv_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start held");
  property p_start_after;
    $fell(sample_o) |-> ##[0:1] conv_start_o;
  endproperty
  a_start_after: assert property (p_start_after) else $error("no start after window");
  property p_sample_min;
    $rose(sample_o) |-> sample_o [*6];
  endproperty
  a_sample_min: assert property (p_sample_min) else $error("window short");
  property p_chan_valid;
    conv_start_o |-> conv_channel_o != 3'h0;
  endproperty
  a_chan_valid: assert property (p_chan_valid) else $error("start on no channel");
  property p_chan_hold;
    sample_o && $past(sample_o) |-> $stable(conv_channel_o);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved in window");
  c_ack: cover property (wb_ack_o);
  c_start: cover property (conv_start_o);
  c_alert: cover property ($fell(irq_n_o));
endmodule
bind tcs_sequencer tcs_seq_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .conv_start_o(conv_start_o),
  .conv_channel_o(conv_channel_o), .sample_o(sample_o), .irq_n_o(irq_n_o));
`default_nettype wire

// File: tcs_conv_model.sv
/*
  behavioural converter core answering each start lat plus one cycles later.
  assumes one start at a time; result is base plus channel code.
*/
`timescale 1ns/1ps
`default_nettype none
module tcs_conv_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [2:0]  chan,
  input  wire logic [3:0]  lat,
  input  wire logic [11:0] base,
  output var  logic        done,
  output var  logic [11:0] data
);
  logic        busy_r;
  logic [3:0]  cnt_r;
  logic [11:0] val_r;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r  <= 4'h0;
      val_r  <= 12'h000;
      done   <= 1'b0;
      data   <= 12'h000;
    end else begin
      done <= 1'b0;
      // data is only valid with done
      if (done) begin
        data <= ~data;
      end
      if (start) begin
        busy_r <= 1'b1;
        cnt_r  <= lat;
        val_r  <= base + {9'h000, chan};
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        done   <= 1'b1;
        data   <= val_r;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: touch_conversion_sequencer_test.sv
/*
  register-level bench for the touch conversion sequencer.
  assumes shortened timing parameters and the converter model.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_conversion_sequencer_test;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic        touch   = 1'b0;
  logic        gpio    = 1'b0;
  logic [3:0]  sel     = 4'h3;
  logic [3:0]  lat     = 4'h3;
  logic [11:0] base    = 12'h100;
  logic [7:0]  seen    = 8'h00;
  logic [15:0] rd;
  wire  [31:0] rdat;
  wire         ack, done, start, smp, irq_n, tdo_n;
  wire  [11:0] cdat;
  wire  [2:0]  chan;
  int          fails = 0, num_checks = 0, nstart = 0, scnt = 0, slen = 0, k, g1, g2, n0;
  time         t_last = 0, t_prev = 0;
  always #50 sys_clk = ~sys_clk;
  tcs_sequencer #(.CONV_DIV(2), .TMR_BASE_TICKS(20), .TMR_STEP_TICKS(2), .SETTLE_UNIT_TICKS(2)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .touch_i(touch),
    .gpio_alert_i(gpio), .conv_done_i(done), .conv_data_i(cdat), .conv_start_o(start),
    .conv_channel_o(chan), .sample_o(smp), .irq_n_o(irq_n), .touch_detect_output_n_o(tdo_n));
  tcs_conv_model u_conv (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .chan(chan), .lat(lat),
    .base(base), .done(done), .data(cdat));
  always @(posedge sys_clk) begin
    // a control one write starts a fresh channel record
    if (cyc && stb && we && adr[5:2] == 4'h1)
      seen <= 8'h00;
    if (start) begin
      nstart <= nstart + 1;
      seen[chan] <= 1'b1;
      t_prev <= t_last;
      t_last <= $time;
    end
    if (smp) begin
      scnt <= scnt + 1;
    end else if (scnt != 0) begin
      slen <= scnt;
      scnt <= 0;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    wdat <= {16'h0000, d};
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50) fails++;
    rd = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    wb(1'b1, idx, d);
  endtask
  task automatic rdchk(input logic [3:0] idx, input logic [15:0] e, input string nm);
    wb(1'b0, idx, 16'h0000);
    chk(nm, e, rd);
  endtask
  task automatic wait_starts(input int n, output int c);
    c = 0;
    while (nstart < n && c < 4000) begin
      @(posedge sys_clk);
      c++;
    end
    if (c == 4000) fails++;
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic limit_run(input logic [15:0] c3, input logic [15:0] e3, input logic e_irq);
    n0 = nstart;
    wr(4'h3, c3);
    wr(4'h1, 16'h8800);
    wait_starts(n0 + 1, k);
    rdchk(4'h3, e3, "alert flags");
    chk("alert pin", {15'h0, e_irq}, {15'h0, irq_n});
    chk("touch pin", {15'h0, e_irq}, {15'h0, tdo_n});
  endtask
  task automatic timer_gap(input logic [7:0] code, output int g);
    n0 = nstart;
    wr(4'h1, {8'h08, code});
    wait_starts(n0 + 3, k);
    g = int'((t_last - t_prev) / 100);
    rdchk(4'h1, {8'h08, code}, "mode kept");
    wr(4'h1, 16'h0000);
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 16; i++) begin
      rdchk(i[3:0], (i == 14) ? 16'h015a : 16'h0000, "reset value");
    end
    for (int i = 4; i < 8; i++) begin
      wr(i[3:0], 16'ha5c0 + i[15:0]);
      rdchk(i[3:0], 16'ha5c0 + i[15:0], "limit");
    end
    sel <= 4'h1;
    wr(4'h4, 16'h1234);
    sel <= 4'h3;
    rdchk(4'h4, 16'ha534, "byte lane");
    wr(4'h8, 16'hffff);
    rdchk(4'h8, 16'h0000, "read-only result");
    wr(4'h1, 16'h7400);
    wait_starts(1, k);
    chk("ready pin", 16'h0000, {15'h0, irq_n});
    rdchk(4'h1, 16'h7000, "mode cleared");
    rdchk(4'h8, 16'h0107, "y result");
    repeat (2) @(posedge sys_clk);
    chk("ready cleared", 16'h0001, {15'h0, irq_n});
    wr(4'h2, 16'h2000);
    wr(4'h3, 16'h00fe);
    n0 = nstart;
    wr(4'h1, 16'h0800);
    wait_starts(n0 + 5, k);
    chk("pin-enabled channels", 16'h00f2, {8'h00, seen});
    rdchk(4'h9, 16'h0106, "x result");
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h000c);
    n0 = nstart;
    wr(4'h1, 16'h0800);
    wait_starts(n0 + 1, k);
    chk("aux and battery", 16'h0004, {8'h00, seen});
    rdchk(4'hc, 16'h0102, "battery result");
    wr(4'h6, 16'h0000);
    wr(4'h7, 16'h0000);
    limit_run(16'h3002, 16'h3102, 1'b0);
    limit_run(16'hb002, 16'hb102, 1'b1);
    limit_run(16'h3008, 16'h3808, 1'b0);
    limit_run(16'h7008, 16'h7808, 1'b1);
    gpio <= 1'b1;
    limit_run(16'h6008, 16'h6808, 1'b0);
    limit_run(16'h7008, 16'h7808, 1'b1);
    gpio <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      n0 = nstart;
      wr(4'h1, 16'h0800 | (c[15:0] << 8));
      wait_starts(n0 + 1, k);
      chk("window", 16'h0001, {15'h0, (slen >= (8 << c) - 2) && (slen <= (8 << c) + 2)});
    end
    wr(4'h2, 16'h000f);
    n0 = nstart;
    wr(4'h1, 16'h0800);
    wait_starts(n0 + 1, g1);
    wr(4'h2, 16'h0000);
    n0 = nstart;
    wr(4'h1, 16'h0800);
    wait_starts(n0 + 1, g2);
    chk("settle table", 16'h0001, {15'h0, (g1 - g2 >= 120) && (g1 - g2 <= 128)});
    timer_gap(8'h01, g1);
    timer_gap(8'h0b, g2);
    chk("interval step", 16'h0001, {15'h0, (g2 - g1 >= 36) && (g2 - g1 <= 44)});
    chk("interval base", 16'h0001, {15'h0, (g1 >= 50) && (g1 <= 80)});
    n0 = nstart;
    repeat (200) @(posedge sys_clk);
    chk("idle no start", 16'h0001, {15'h0, nstart == n0});
    lat <= 4'h9;
    wr(4'h1, 16'h0c01);
    repeat (300) @(posedge sys_clk);
    chk("no touch no start", 16'h0001, {15'h0, nstart == n0});
    chk("touch pin idle", 16'h0001, {15'h0, tdo_n});
    touch <= 1'b1;
    wait_starts(n0 + 1, k);
    chk("touch starts at once", 16'h0001, {15'h0, k < 30});
    chk("touch pin low", 16'h0000, {15'h0, tdo_n});
    wait_starts(n0 + 3, k);
    touch <= 1'b0;
    repeat (60) @(posedge sys_clk);
    n0 = nstart;
    repeat (300) @(posedge sys_clk);
    chk("release stops timer", 16'h0001, {15'h0, nstart == n0});
    touch <= 1'b1;
    wait_starts(n0 + 1, k);
    chk("retouch starts", 16'h0001, {15'h0, k < 30});
    touch <= 1'b0;
    repeat (60) @(posedge sys_clk);
    wr(4'h1, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
